// File: byte_op_defs.svh
`ifndef BYTE_OP_DEFS_SVH
`define BYTE_OP_DEFS_SVH

// Instruction word fields
`define OPC_HI        15
`define OPC6_LO       10
`define OPC7_LO       9
`define OPC4_LO       12
`define DEST_BIT      9
`define ACC_BIT       8
`define FADDR_HI      7
`define LADDR_HI      11

// Six-bit opcode prefixes (destination and access bits follow)
`define PAT_ADD       6'h09
`define PAT_ADD_C     6'h08
`define PAT_AND       6'h05
`define PAT_COMP      6'h07
`define PAT_DEC       6'h01
`define PAT_DEC_SZ    6'h0B
`define PAT_DEC_SNZ   6'h13
`define PAT_INC       6'h0A
`define PAT_INC_SZ    6'h0F
`define PAT_INC_SNZ   6'h12
`define PAT_OR        6'h04
`define PAT_MOVE      6'h14
`define PAT_RL_C      6'h0D
`define PAT_RL        6'h11
`define PAT_RR_C      6'h0C
`define PAT_RR        6'h10
`define PAT_REV_SUB_B 6'h15
`define PAT_SUB       6'h17
`define PAT_SUB_B     6'h16
`define PAT_SWAP      6'h0E
`define PAT_XOR       6'h06

// Seven-bit opcode prefixes (access bit follows)
`define PAT_SKIP_LT   7'h30
`define PAT_SKIP_EQ   7'h31
`define PAT_SKIP_GT   7'h32
`define PAT_TEST_SKIP 7'h33
`define PAT_SET       7'h34
`define PAT_CLEAR     7'h35
`define PAT_NEG       7'h36
`define PAT_MOVE_W    7'h37
`define PAT_MUL       7'h01

// Four-bit prefixes of the two-word move
`define PAT_MOVE_FF   4'hC
`define PAT_SECOND    4'hF

// Addressing
`define ACCESS_SPLIT  8'h60
`define ACCESS_LO_PG  4'h0
`define ACCESS_HI_PG  4'hF
`define PORT_BASE     12'hF80
`define PORT_COUNT    5
`define TIMER_ZERO    12'hFD6

// Register port map and status layout
`define REG_BANK      4'h0
`define REG_WORK      4'h1
`define REG_STATUS    4'h2
`define FLAG_C        0
`define FLAG_DC       1
`define FLAG_Z        2
`define FLAG_OV       3
`define FLAG_N        4
`define BYTE_ZERO     8'h00
`define BYTE_ONES     8'hFF

`endif

// File: byte_op_pkg.sv
package byte_op_pkg;

  typedef enum logic [3:0] {
    ST_FETCH     = 4'h1,
    ST_EXEC      = 4'h2,
    ST_MOVE_READ = 4'h4,
    ST_MOVE_DEST = 4'h8
  } state_type;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_AND, OP_CLEAR, OP_COMPLEMENT,
    OP_SKIP_EQ, OP_SKIP_GT, OP_SKIP_LT, OP_DEC, OP_DEC_SKIP_Z, OP_DEC_SKIP_NZ,
    OP_INC, OP_INC_SKIP_Z, OP_INC_SKIP_NZ, OP_OR, OP_MOVE, OP_MOVE_FF,
    OP_MOVE_W, OP_MUL, OP_NEG, OP_RL_C, OP_RL, OP_RR_C, OP_RR, OP_SET,
    OP_REV_SUB_B, OP_SUB, OP_SUB_B, OP_SWAP, OP_TEST_SKIP, OP_XOR
  } op_type;

endpackage : byte_op_pkg

// File: byte_op_instruction_decoder.sv
// Overview of operation
// - Add with carry: working register plus carry plus file; updates C, DC, Z, OV, N.
// - Compare equal skips next instruction on file equal working register; flags untouched.
// - Compare greater skips when file exceeds working register; flags untouched.
// - Compare less skips when file is below working register; flags untouched.
// - Decrement, skip when result is zero; no flag change.
// - Decrement, skip when result is nonzero; no flag change.
// - Increment, skip when result is zero; no flag change.
// - Increment, skip when result is nonzero; no flag change.
// - OR of working register and file; updates Z and N only.
// - XOR of working register and file; updates Z and N only.
// - Multiply working register by file in one cycle; no flag change.
// - Rotate left through carry; updates C, Z, N.
// - Eight-bit rotate left without carry; updates Z and N.
// - Rotate right through carry; updates C, Z, N.
// - Eight-bit rotate right without carry; updates Z and N.
// - Working register minus file minus borrow; updates all five arithmetic flags.
// - File minus working register minus borrow; updates all five arithmetic flags.
// - File minus working register; updates all five arithmetic flags.
// - Read-modify-write of a port uses pin levels, not the output latch.
// - Result written back to the timer count clears its prescaler.
// - A taken skip costs an extra cycle, two over a two-word move, each behaving as a no-operation.
// - Second word of a two-word instruction executes as no-operation unless consumed.
// - Destination bit sends result to working register or back to file.
// - Low eight word bits give the file address within the bank.
// - Two-word move takes twelve-bit source and destination addresses.
`include "byte_op_defs.svh"

module byte_op_instruction_decoder import byte_op_pkg::*; (
  // Clock and control
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Program memory fetch
  input  wire logic [15:0]              instr_word,
  input  wire logic                     instr_valid,
  output logic                          instr_ready,
  output logic                          skip_taken,
  // Data register file
  output logic [11:0]                   file_addr,
  input  wire logic [7:0]               file_rdata,
  output logic [7:0]                    file_wdata,
  output logic                          file_we,
  // Port pins and timer
  input  wire logic [`PORT_COUNT*8-1:0] port_pins,
  output logic                          prescaler_clear,
  // Multiplier result
  output logic [15:0]                   product,
  output logic                          product_we,
  // Core state
  output logic [7:0]                    working_register,
  output logic                          carry,
  output logic                          half_carry_flag,
  output logic                          zero,
  output logic                          signed_wrap_flag,
  output logic                          negative,
  // Register port
  input  wire logic [3:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [7:0]                    reg_rdata
);

  function automatic op_type decode_op(input logic [15:0] w);
    op_type op;
    op = OP_NOP;
    if (w[`OPC_HI:`OPC4_LO] == `PAT_MOVE_FF) begin
      op = OP_MOVE_FF;
    end else begin
      case (w[`OPC_HI:`OPC7_LO])
        `PAT_SKIP_LT:   op = OP_SKIP_LT;
        `PAT_SKIP_EQ:   op = OP_SKIP_EQ;
        `PAT_SKIP_GT:   op = OP_SKIP_GT;
        `PAT_TEST_SKIP: op = OP_TEST_SKIP;
        `PAT_SET:       op = OP_SET;
        `PAT_CLEAR:     op = OP_CLEAR;
        `PAT_NEG:       op = OP_NEG;
        `PAT_MOVE_W:    op = OP_MOVE_W;
        `PAT_MUL:       op = OP_MUL;
        default: begin
          case (w[`OPC_HI:`OPC6_LO])
            `PAT_ADD:       op = OP_ADD;
            `PAT_ADD_C:     op = OP_ADD_CARRY;
            `PAT_AND:       op = OP_AND;
            `PAT_COMP:      op = OP_COMPLEMENT;
            `PAT_DEC:       op = OP_DEC;
            `PAT_DEC_SZ:    op = OP_DEC_SKIP_Z;
            `PAT_DEC_SNZ:   op = OP_DEC_SKIP_NZ;
            `PAT_INC:       op = OP_INC;
            `PAT_INC_SZ:    op = OP_INC_SKIP_Z;
            `PAT_INC_SNZ:   op = OP_INC_SKIP_NZ;
            `PAT_OR:        op = OP_OR;
            `PAT_MOVE:      op = OP_MOVE;
            `PAT_RL_C:      op = OP_RL_C;
            `PAT_RL:        op = OP_RL;
            `PAT_RR_C:      op = OP_RR_C;
            `PAT_RR:        op = OP_RR;
            `PAT_REV_SUB_B: op = OP_REV_SUB_B;
            `PAT_SUB:       op = OP_SUB;
            `PAT_SUB_B:     op = OP_SUB_B;
            `PAT_SWAP:      op = OP_SWAP;
            `PAT_XOR:       op = OP_XOR;
            default:        op = OP_NOP;
          endcase
        end
      endcase
    end
    return op;
  endfunction : decode_op

  // Access bank: low part of page zero, high part of the top page
  function automatic logic [11:0] bank_address(input logic [7:0] f, input logic acc, input logic [3:0] bsel);
    logic [11:0] a;
    if (acc) begin
      a = {bsel, f};
    end else if (f < `ACCESS_SPLIT) begin
      a = {`ACCESS_LO_PG, f};
    end else begin
      a = {`ACCESS_HI_PG, f};
    end
    return a;
  endfunction : bank_address

  state_type   state, next_state;
  op_type      cur_op, next_op;
  logic        dest_file, next_dest_file;
  logic        skip_pending, next_skip_pending;
  logic [7:0]  move_data, next_move_data;
  logic [3:0]  bank, next_bank;
  logic [`PORT_COUNT*8-1:0] port_meta, port_sync;
  logic [11:0] next_file_addr;
  logic [7:0]  next_file_wdata, next_working_register, next_reg_rdata;
  logic [15:0] next_product;
  logic        next_file_we, next_product_we, next_prescaler_clear, next_skip_taken, next_instr_ready;
  logic        next_carry, next_half, next_zero, next_wrap, next_negative;
  logic [11:0] instr_low;
  logic        taken, is_port, reads_file;
  logic [2:0]  port_index;
  logic [7:0]  operand, a_in, b_in, result;
  logic        cin, upd_c, upd_dc, upd_ov, upd_z, upd_n, has_result, do_skip;
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  op_type      fetched_op;

  assign instr_low  = instr_word[`LADDR_HI:0];
  assign taken      = instr_valid && instr_ready;
  assign fetched_op = decode_op(instr_word);
  assign is_port    = (file_addr >= `PORT_BASE) && (file_addr < `PORT_BASE + 12'(`PORT_COUNT));
  assign port_index = 3'(file_addr - `PORT_BASE);
  assign reads_file = !(cur_op inside {OP_CLEAR, OP_SET, OP_MOVE_W});
  // Pins are asynchronous to the core; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_meta <= '0;
      port_sync <= '0;
    end else if (ce) begin
      port_meta <= port_pins;
      port_sync <= port_meta;
    end
  end
  // Arithmetic operand selection and flag-update set
  always_comb begin
    operand = file_rdata;
    if (is_port && dest_file && reads_file) begin
      operand = port_sync[port_index*8 +: 8];
    end
    a_in = operand;
    b_in = `BYTE_ZERO;
    cin  = 1'b0;
    unique case (cur_op)
      OP_ADD:       b_in = working_register;
      OP_ADD_CARRY: begin b_in = working_register; cin = carry; end
      OP_SUB:       begin b_in = ~working_register; cin = 1'b1; end
      OP_SUB_B:     begin b_in = ~working_register; cin = carry; end
      OP_REV_SUB_B: begin a_in = working_register; b_in = ~operand; cin = carry; end
      OP_DEC, OP_DEC_SKIP_Z, OP_DEC_SKIP_NZ: b_in = `BYTE_ONES;
      OP_INC, OP_INC_SKIP_Z, OP_INC_SKIP_NZ: cin = 1'b1;
      OP_NEG:       begin a_in = `BYTE_ZERO; b_in = ~operand; cin = 1'b1; end
      default:      cin = 1'b0;
    endcase
    sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
    nib5 = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
    result     = sum9[7:0];
    has_result = 1'b1;
    do_skip    = 1'b0;
    upd_c = 1'b0; upd_dc = 1'b0; upd_ov = 1'b0; upd_z = 1'b0; upd_n = 1'b0;
    unique case (cur_op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_B, OP_REV_SUB_B, OP_DEC, OP_INC, OP_NEG: begin
        upd_c = 1'b1; upd_dc = 1'b1; upd_ov = 1'b1; upd_z = 1'b1; upd_n = 1'b1;
      end
      OP_DEC_SKIP_Z, OP_INC_SKIP_Z:   do_skip = (sum9[7:0] == `BYTE_ZERO);
      OP_DEC_SKIP_NZ, OP_INC_SKIP_NZ: do_skip = (sum9[7:0] != `BYTE_ZERO);
      OP_AND:        begin result = working_register & operand; upd_z = 1'b1; upd_n = 1'b1; end
      OP_OR:         begin result = working_register | operand; upd_z = 1'b1; upd_n = 1'b1; end
      OP_XOR:        begin result = working_register ^ operand; upd_z = 1'b1; upd_n = 1'b1; end
      OP_COMPLEMENT: begin result = ~operand; upd_z = 1'b1; upd_n = 1'b1; end
      OP_MOVE:       begin result = operand; upd_z = 1'b1; upd_n = 1'b1; end
      OP_CLEAR:      begin result = `BYTE_ZERO; upd_z = 1'b1; end
      OP_SET:        result = `BYTE_ONES;
      OP_MOVE_W:     result = working_register;
      OP_SWAP:       result = {operand[3:0], operand[7:4]};
      OP_RL_C:       begin result = {operand[6:0], carry}; upd_c = 1'b1; upd_z = 1'b1; upd_n = 1'b1; end
      OP_RR_C:       begin result = {carry, operand[7:1]}; upd_c = 1'b1; upd_z = 1'b1; upd_n = 1'b1; end
      OP_RL:         begin result = {operand[6:0], operand[7]}; upd_z = 1'b1; upd_n = 1'b1; end
      OP_RR:         begin result = {operand[0], operand[7:1]}; upd_z = 1'b1; upd_n = 1'b1; end
      OP_SKIP_EQ:    begin has_result = 1'b0; do_skip = (operand == working_register); end
      OP_SKIP_GT:    begin has_result = 1'b0; do_skip = (operand > working_register); end
      OP_SKIP_LT:    begin has_result = 1'b0; do_skip = (operand < working_register); end
      OP_TEST_SKIP:  begin has_result = 1'b0; do_skip = (operand == `BYTE_ZERO); end
      default:       has_result = 1'b0;
    endcase
  end
  // Sequencing and write-back
  always_comb begin
    next_state            = state;
    next_op               = cur_op;
    next_dest_file        = dest_file;
    next_skip_pending     = skip_pending;
    next_move_data        = move_data;
    next_file_addr        = file_addr;
    next_file_wdata       = file_wdata;
    next_working_register = working_register;
    next_product          = product;
    next_carry            = carry;
    next_half             = half_carry_flag;
    next_zero             = zero;
    next_wrap             = signed_wrap_flag;
    next_negative         = negative;
    next_file_we          = 1'b0;
    next_product_we       = 1'b0;
    next_skip_taken       = 1'b0;
    unique case (state)
      ST_FETCH: begin
        if (taken && skip_pending) begin
          // Discarded word; a skipped two-word move also drops its second word
          next_skip_pending = (fetched_op == OP_MOVE_FF);
        end else if (taken) begin
          next_op        = fetched_op;
          next_dest_file = instr_word[`DEST_BIT] || (fetched_op inside {OP_CLEAR, OP_SET, OP_NEG, OP_MOVE_W});
          next_file_addr = bank_address(instr_word[`FADDR_HI:0], instr_word[`ACC_BIT], bank);
          if (fetched_op == OP_MOVE_FF) begin
            next_file_addr = instr_low;
            next_state     = ST_MOVE_READ;
          end else if (fetched_op != OP_NOP) begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_state = ST_FETCH;
        if (has_result) begin
          if (dest_file) begin
            next_file_wdata = result;
            next_file_we    = 1'b1;
          end else begin
            next_working_register = result;
          end
        end
        if (cur_op == OP_MUL) begin
          next_product    = {8'h00, working_register} * {8'h00, operand};
          next_product_we = 1'b1;
        end
        if (upd_c) next_carry = (cur_op == OP_RL_C) ? operand[7] : (cur_op == OP_RR_C) ? operand[0] : sum9[8];
        if (upd_dc) next_half = nib5[4];
        if (upd_ov) next_wrap = (a_in[7] == b_in[7]) && (sum9[7] != a_in[7]);
        if (upd_z) next_zero = (result == `BYTE_ZERO);
        if (upd_n) next_negative = result[7];
        if (do_skip) begin
          next_skip_pending = 1'b1;
          next_skip_taken   = 1'b1;
        end
      end
      ST_MOVE_READ: begin
        next_move_data = file_rdata;
        next_state     = ST_MOVE_DEST;
      end
      ST_MOVE_DEST: begin
        // The second word is consumed here, never executed on its own
        if (taken) begin
          next_file_addr  = instr_low;
          next_file_wdata = move_data;
          next_file_we    = 1'b1;
          next_state      = ST_FETCH;
        end
      end
    endcase
    next_prescaler_clear = next_file_we && (next_file_addr == `TIMER_ZERO);
    next_instr_ready     = (next_state == ST_FETCH) || (next_state == ST_MOVE_DEST);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state            <= ST_FETCH;
      cur_op           <= OP_NOP;
      dest_file        <= 1'b0;
      skip_pending     <= 1'b0;
      move_data        <= '0;
      file_addr        <= '0;
      file_wdata       <= '0;
      file_we          <= 1'b0;
      working_register <= '0;
      product          <= '0;
      product_we       <= 1'b0;
      carry            <= 1'b0;
      half_carry_flag  <= 1'b0;
      zero             <= 1'b0;
      signed_wrap_flag <= 1'b0;
      negative         <= 1'b0;
      skip_taken       <= 1'b0;
      prescaler_clear  <= 1'b0;
      instr_ready      <= 1'b1;
    end else if (ce) begin
      state            <= next_state;
      cur_op           <= next_op;
      dest_file        <= next_dest_file;
      skip_pending     <= next_skip_pending;
      move_data        <= next_move_data;
      file_addr        <= next_file_addr;
      file_wdata       <= next_file_wdata;
      file_we          <= next_file_we;
      working_register <= next_working_register;
      product          <= next_product;
      product_we       <= next_product_we;
      carry            <= next_carry;
      half_carry_flag  <= next_half;
      zero             <= next_zero;
      signed_wrap_flag <= next_wrap;
      negative         <= next_negative;
      skip_taken       <= next_skip_taken;
      prescaler_clear  <= next_prescaler_clear;
      instr_ready      <= next_instr_ready;
    end
  end
  // Register port; bank select steers the banked address
  always_comb begin
    next_bank      = bank;
    next_reg_rdata = `BYTE_ZERO;
    if (reg_wr && reg_addr == `REG_BANK) begin
      next_bank = reg_wdata[3:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_BANK:   next_reg_rdata = {4'h0, bank};
        `REG_WORK:   next_reg_rdata = working_register;
        `REG_STATUS: begin
          next_reg_rdata[`FLAG_C]  = carry;
          next_reg_rdata[`FLAG_DC] = half_carry_flag;
          next_reg_rdata[`FLAG_Z]  = zero;
          next_reg_rdata[`FLAG_OV] = signed_wrap_flag;
          next_reg_rdata[`FLAG_N]  = negative;
        end
        default:     next_reg_rdata = `BYTE_ZERO;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bank      <= '0;
      reg_rdata <= '0;
    end else if (ce) begin
      bank      <= next_bank;
      reg_rdata <= next_reg_rdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_add_carry_sum: assert property ((ce && state == ST_EXEC && cur_op == OP_ADD_CARRY && !dest_file) |=>
    working_register == 8'($past(working_register) + $past(operand) + {7'h00, $past(carry)}))
    else $error("add with carry result wrong");
  a_equal_skip: assert property ((ce && state == ST_EXEC && cur_op == OP_SKIP_EQ && operand == working_register) |=>
    skip_taken && $stable(carry) && $stable(zero) && $stable(negative))
    else $error("equal compare did not skip cleanly");
  a_greater_noskip: assert property ((ce && state == ST_EXEC && cur_op == OP_SKIP_GT && operand <= working_register) |=>
    !skip_taken)
    else $error("greater compare skipped wrongly");
  a_skip_discard: assert property ((ce && state == ST_FETCH && skip_pending && taken && fetched_op != OP_MOVE_FF) |=>
    state == ST_FETCH && !skip_pending && !file_we)
    else $error("skipped word was executed");
  a_or_flags: assert property ((ce && state == ST_EXEC && cur_op == OP_OR) |=>
    $stable(carry) && $stable(signed_wrap_flag) && zero == (($past(working_register) | $past(operand)) == 8'h00))
    else $error("or flag update wrong");
  a_mul_product: assert property ((ce && state == ST_EXEC && cur_op == OP_MUL) |=>
    product_we && product == $past(working_register) * $past(operand) && $stable(zero) && $stable(carry))
    else $error("multiply wrong");
  a_move_dest: assert property ((ce && state == ST_MOVE_DEST && taken) |=>
    file_we && file_addr == $past(instr_low) && file_wdata == $past(move_data))
    else $error("two-word move write wrong");
  a_dest_working: assert property ((ce && state == ST_EXEC && !dest_file) |=> !file_we)
    else $error("file written with working destination");
  a_timer_clear: assert property ((file_we && file_addr == `TIMER_ZERO) |-> prescaler_clear)
    else $error("prescaler not cleared");
endmodule : byte_op_instruction_decoder

// File: file_store_model.sv
module file_store_model (
  // Clock
  input  wire logic        sys_clk,
  // File port of the decoder
  input  wire logic [11:0] file_addr,
  input  wire logic [7:0]  file_wdata,
  input  wire logic        file_we,
  output logic [7:0]       file_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  // Read follows the address at once, so the decoder sees it well before its next edge
  assign file_rdata = mem[file_addr];
  always @(posedge sys_clk) begin
    if (file_we)
      mem[file_addr] <= file_wdata;
  end
endmodule : file_store_model

// File: tb_byte_op_instruction_decoder.sv
module tb_byte_op_instruction_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [39:0] port_pins = 40'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, w = 8'h00, fv, r, file_rdata, file_wdata, working_register, reg_rdata;
  logic [4:0]  s = 5'h00, flags;
  logic [31:0] rng = 32'h0000003D;
  logic [11:0] file_addr;
  logic [15:0] product;
  logic        instr_ready, skip_taken, file_we, prescaler_clear, product_we, sk, d;
  logic        carry, half_carry_flag, zero, signed_wrap_flag, negative;
  int          fail_count = 0, num_checks = 0, pc_cnt = 0, i, k;
  logic [5:0]  ops [16] = '{6'h08, 6'h04, 6'h06, 6'h0D, 6'h11, 6'h0C, 6'h10, 6'h15, 6'h16, 6'h17, 6'h14,
                            6'h09, 6'h05, 6'h07, 6'h01, 6'h0A};
  logic [5:0]  sks [4] = '{6'h0B, 6'h13, 6'h0F, 6'h12};
  assign flags = {negative, signed_wrap_flag, zero, half_carry_flag, carry};

  byte_op_instruction_decoder i_dut (.sys_clk, .rst_n, .ce, .instr_word, .instr_valid, .instr_ready, .skip_taken,
    .file_addr, .file_rdata, .file_wdata, .file_we, .port_pins, .prescaler_clear, .product, .product_we,
    .working_register, .carry, .half_carry_flag, .zero, .signed_wrap_flag, .negative,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  file_store_model i_mem (.sys_clk, .file_addr, .file_wdata, .file_we, .file_rdata);

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (prescaler_clear === 1'b1) pc_cnt++;

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rnd

  // Returns {N, OV, Z, DC, C, result}; subtract carry means no borrow
  function automatic logic [12:0] ref_op(input logic [5:0] p, input logic [7:0] f, input logic [7:0] wv,
                                         input logic [4:0] st);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] a, b, q;
    logic       ci;
    a = (p == 6'h15) ? wv : f;
    b = (p == 6'h15) ? ~f : (p > 6'h15) ? ~wv : (p == 6'h01) ? 8'hFF : (p == 6'h0A) ? 8'h00 : wv;
    ci = (p == 6'h17) || (p == 6'h0A) || (st[0] && (p inside {6'h08, 6'h15, 6'h16}));
    t = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    case (p)
      6'h04: q = f | wv;
      6'h06: q = f ^ wv;
      6'h05: q = f & wv;
      6'h07: q = ~f;
      6'h0D: {st[0], q} = {f, st[0]};
      6'h11: q = {f[6:0], f[7]};
      6'h0C: {q, st[0]} = {st[0], f};
      6'h10: q = {f[0], f[7:1]};
      6'h14: q = f;
      default: begin
        q = t[7:0];
        st[0] = t[8];
        st[1] = h[4];
        st[3] = (a[7] == b[7]) && (q[7] != a[7]);
      end
    endcase
    st[2] = (q == 8'h00);
    st[4] = q[7];
    return {st, q};
  endfunction : ref_op

  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the word until the edge that samples ready high
  task automatic issue(input logic [15:0] wd);
    @(posedge sys_clk);
    instr_word <= wd;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    while (instr_ready !== 1'b1) @(posedge sys_clk);
    instr_valid <= 1'b0;
  endtask : issue

  task automatic wait2();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : wait2

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask : rd

  initial begin
    #40000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    port_pins <= {rnd(), rnd(), rnd(), rnd(), rnd()};
    #1 chk(16'(instr_ready), 16'h0001);
    for (i = 0; i < 48; i++) begin
      k = i % 16;
      d = (i % 3 == 2);
      fv = rnd();
      i_mem.mem[12'h010 + k] = fv;
      issue({ops[k], d, 1'b0, 8'h10 + 8'(k)});
      {s, r} = ref_op(ops[k], fv, w, s);
      if (!d) w = r;
      wait2();
      chk(16'(d ? i_mem.mem[12'h010 + k] : working_register), 16'(r));
      chk(16'(flags), 16'(s));
    end
    i_mem.mem[12'h020] = 8'h80;
    issue(16'h5020);
    {s, w} = ref_op(6'h14, 8'h80, w, s);
    wait2();
    for (i = 0; i < 21; i++) begin
      k = i % 7;
      fv = (i < 7) ? 8'h01 : (i < 14) ? 8'hFF : 8'h80;
      i_mem.mem[12'h030] = fv;
      i_mem.mem[12'h031] = 8'h00;
      r = (k < 5) ? fv - 8'h01 : fv + 8'h01;
      sk = (k == 0) ? fv < w : (k == 1) ? fv == w : (k == 2) ? fv > w : ((r == 8'h00) == k[0]);
      issue((k < 3) ? {7'h30 + 7'(k), 1'b0, 8'h30} : {sks[k - 3], 2'b10, 8'h30});
      // Skip pulse stands only in the cycle after execution
      @(posedge sys_clk);
      #1 chk(16'(skip_taken), 16'(sk));
      @(posedge sys_clk);
      #1;
      chk(16'(flags), 16'(s));
      if (k > 2) chk(16'(i_mem.mem[12'h030]), 16'(r));
      issue(16'h1231);
      if (!sk) {s, r} = ref_op(6'h04, 8'h00, w, s);
      wait2();
      chk(16'(i_mem.mem[12'h031]), 16'(sk ? 8'h00 : w));
    end
    fv = rnd();
    i_mem.mem[12'h040] = fv;
    issue(16'h0240);
    @(posedge sys_clk);
    #1 chk(16'(product_we), 16'h0001);
    chk(product, 16'(w) * 16'(fv));
    issue(16'hC040);
    issue(16'hFFD6);
    wait2();
    chk(16'(i_mem.mem[12'hFD6]), 16'(fv));
    chk(16'(pc_cnt), 16'h0001);
    issue(16'hF123);
    issue(16'h5280);
    {s, r} = ref_op(6'h14, port_pins[7:0], w, s);
    wait2();
    chk(16'(i_mem.mem[12'hF80]), 16'(port_pins[7:0]));
    chk({flags, working_register}, {s, w});
    rd(4'h2, {3'h0, s});
    rd(4'h1, w);
    rd(4'hF, 8'h00);
    @(posedge sys_clk);
    reg_addr <= 4'h0;
    reg_wdata <= rnd();
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    rd(4'h0, {4'h0, reg_wdata[3:0]});
    i_mem.mem[{reg_wdata[3:0], 8'h50}] = 8'h3C;
    issue(16'h5150);
    wait2();
    chk(16'(working_register), 16'h003C);
    // A word offered while the enable is low must not be taken
    @(posedge sys_clk);
    ce <= 1'b0;
    instr_word <= 16'h5020;
    instr_valid <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ce <= 1'b1;
    #1 chk(16'({instr_ready, working_register}), 16'h013C);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    wait2();
    chk(16'(working_register), 16'h0080);
    tally_and_finish();
  end
endmodule : tb_byte_op_instruction_decoder
